//--- hdl/stg_glue.v
// Main-board glue around a serial port part and a three-channel timer part.
// Assumes the CPU presents one-cycle peripheral strobes synchronous to clk,
// and the serial and timer parts sit outside behind their select lines.
// Contract
// - Serial part decoded at 10h-1Fh, even only
// - Serial data at 10h, status/control at 12h
// - Serial part gets 2 MHz master clock
// - Timer part decoded at 40h-4Fh, even only
// - Counters at 40h/42h/44h, mode word 46h
// - Timer yields tone, baud clock, refresh pulses
// - Timer channel 0 at 1 MHz, others 2 MHz
// - Four halving stages from 8 MHz clock
// - Selected baud clock feeds both serial clocks
// - Control port bit map at 00h
// - Control port clears on reset
// - Serial interrupt is receive-ready OR transmit-ready
// - Receive-ready set on character, cleared on read
// - Transmit-empty high when idle, cleared by write
// - Invert six modem lines through the board
// - Gate and data high: tone from timer 0
// - Gate low: speaker follows data bit
// - Timer 2 output is refresh request
// - Refresh and timer baud pass only with bit 4
// - Strapped 8-bit board revision value readable
// - Bit 5 low drives disk reset active
`timescale 1ns/1ps
`include "stg_regs.vh"
module stg_glue (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       cpuTick,
    input  wire [7:0] perAddr,
    input  wire [7:0] perWdata,
    input  wire       perWr,
    input  wire       perRd,
    output reg  [7:0] perRdata,
    output wire       perAck,
    output wire       serSel,
    output wire       serCmd,
    output wire       serWr,
    output wire       serRd,
    output wire [7:0] serWdata,
    input  wire [7:0] serRdata,
    input  wire       serRxReady,
    input  wire       serTxReady,
    input  wire       serTxEmpty,
    output reg        serClkTick,
    output reg        serBaudTick,
    input  wire       serTxd,
    input  wire       serRts,
    input  wire       serDtr,
    output wire       serRxd,
    output wire       serCts,
    output wire       serDsr,
    input  wire       rs232RxdN,
    input  wire       rs232CtsN,
    input  wire       rs232DsrN,
    input  wire       rs232ClkN,
    output reg        rs232TxdN,
    output reg        rs232RtsN,
    output reg        rs232DtrN,
    output wire       tmrSel,
    output wire [1:0] tmrIndex,
    output wire       tmrWr,
    output wire       tmrRd,
    output wire [7:0] tmrWdata,
    input  wire [7:0] tmrRdata,
    output reg  [2:0] tmrClkTick,
    input  wire [2:0] tmrOut,
    output reg        serialIrq,
    output reg        speakerOut,
    output reg        refreshReq,
    output reg        keyboardPowerOn,
    output reg        diskControllerResetN,
    output reg        cpuTimer0Enable,
    output reg        cpuTimer1Enable,
    input  wire [7:0] boardStrap,
    output reg  [7:0] boardRevision
);
    reg  [7:0] ctrl_reg;
    reg        strapTaken_reg;
    reg        remoteClk_reg;
    reg        baudLevel_reg;
    wire [3:0] stageTick;
    wire [3:0] stageLevel;
    wire       serHit;
    wire       tmrHit;
    wire       ctrlHit;
    wire       baudSrc;

    // Range decode answering only even addresses
    function inRange;
        input [7:0] addr;
        input [7:0] lo;
        input [7:0] hi;
        begin
            inRange = (addr >= lo) && (addr <= hi) && (addr[0] == 1'b0);
        end
    endfunction

    // Divider chain: stage 1 is 2 MHz, stage 2 is 1 MHz
    stg_divider uDiv (
        .clk        (clk),
        .rst_b      (rst_b),
        .cpuTick    (cpuTick),
        .stageTick  (stageTick),
        .stageLevel (stageLevel)
    );

    // Address decode; odd addresses fall through with no select
    assign serHit  = inRange(perAddr, `STG_SER_BASE, `STG_SER_LAST);
    assign tmrHit  = inRange(perAddr, `STG_TMR_BASE, `STG_TMR_LAST);
    assign ctrlHit = (perAddr == `STG_CTRL_ADDR);
    assign perAck  = perWr | perRd;

    // Serial part: A1 picks data or status/control, mirrored over the range
    assign serSel   = serHit & (perWr | perRd);
    assign serCmd   = perAddr[1];
    assign serWr    = serSel & perWr;
    assign serRd    = serSel & perRd;
    assign serWdata = perWdata;

    // Timer part: A2..A1 pick a counter or the mode word
    assign tmrIndex = perAddr[2:1];
    assign tmrSel   = tmrHit & (perWr | perRd);
    assign tmrWr    = tmrSel & perWr;
    assign tmrRd    = tmrSel & perRd & (perAddr[2:1] != 2'b11);
    assign tmrWdata = perWdata;

    // Read data: mode word and control port read as zero (no operation)
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            perRdata <= `STG_ZERO8;
        end else if (perRd) begin
            if (serHit) begin
                perRdata <= serRdata;
            end else if (tmrRd) begin
                perRdata <= tmrRdata;
            end else begin
                perRdata <= `STG_ZERO8; // Write-only latch reads nothing
            end
        end
    end

    // Control latch, loaded only by a write to 00h
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= `STG_CTRL_RESET;
        end else if (perWr && ctrlHit) begin
            ctrl_reg <= perWdata;
        end
    end

    // Control bits out to the board, registered
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            keyboardPowerOn      <= 1'b0;
            diskControllerResetN <= 1'b0;
            cpuTimer0Enable      <= 1'b0;
            cpuTimer1Enable      <= 1'b0;
        end else begin
            keyboardPowerOn      <= ctrl_reg[`STG_BIT_KBD];
            diskControllerResetN <= ctrl_reg[`STG_BIT_FDCRST];
            cpuTimer0Enable      <= ctrl_reg[`STG_BIT_TMR0];
            cpuTimer1Enable      <= ctrl_reg[`STG_BIT_TMR1];
        end
    end

    // Clock enables for the serial and timer parts
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serClkTick <= 1'b0;
            tmrClkTick <= 3'b000;
        end else begin
            serClkTick    <= stageTick[1];
            tmrClkTick[0] <= stageTick[2];
            tmrClkTick[1] <= stageTick[1];
            tmrClkTick[2] <= stageTick[1];
        end
    end

    // Baud source select; remote clock arrives inverted and is restored here.
    // Timer 1 output only passes while bit 4 is set.
    assign baudSrc = ctrl_reg[`STG_BIT_REMOTE_BAUD_CLOCK_SELECT] ? remoteClk_reg
                   : (tmrOut[1] & ctrl_reg[`STG_BIT_RFSH]);

    // Rising edge of the chosen baud level becomes one tick to both serial clocks
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            remoteClk_reg <= 1'b0;
            baudLevel_reg <= 1'b0;
            serBaudTick   <= 1'b0;
        end else begin
            remoteClk_reg <= ~rs232ClkN;
            baudLevel_reg <= baudSrc;
            serBaudTick   <= baudSrc & ~baudLevel_reg;
        end
    end

    // Modem lines are active low at the connector
    assign serRxd = ~rs232RxdN;
    assign serCts = ~rs232CtsN;
    assign serDsr = ~rs232DsrN;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rs232TxdN <= 1'b0;
            rs232RtsN <= 1'b1;
            rs232DtrN <= 1'b1;
        end else begin
            rs232TxdN <= ~serTxd;
            rs232RtsN <= ~serRts;
            rs232DtrN <= ~serDtr;
        end
    end

    // Serial interrupt; the flags themselves are kept by the serial part,
    // which sets ready on a character and clears it on a data read
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serialIrq <= 1'b0;
        end else begin
            serialIrq <= serRxReady | serTxReady;
        end
    end

    // Speaker and refresh outputs driven from timer channels 0 and 2
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            speakerOut <= 1'b0;
            refreshReq <= 1'b0;
        end else begin
            if (!ctrl_reg[`STG_BIT_TGATE]) begin
                speakerOut <= ctrl_reg[`STG_BIT_TDATA];
            end else begin
                // Tone needs data bit too; gate-only leaves the speaker quiet
                speakerOut <= ctrl_reg[`STG_BIT_TDATA] & tmrOut[0];
            end
            refreshReq <= tmrOut[2] & ctrl_reg[`STG_BIT_RFSH];
        end
    end

    // Revision strap caught once after reset release, never under reset
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strapTaken_reg <= 1'b0;
            boardRevision  <= `STG_ZERO8;
        end else if (!strapTaken_reg) begin
            strapTaken_reg <= 1'b1;
            boardRevision  <= boardStrap;
        end
    end

    // Transmit-empty is kept by the serial part and read through its status
    // port only; the board adds no logic to it
    wire unusedTxEmpty = serTxEmpty | stageLevel[0];
endmodule

//--- hdl/stg_regs.vh
// Constants for the serial/timer glue block: decode ranges, offsets,
// control port fields, reset values and divider figures.
// Assumes inclusion by name from the design files.
`ifndef STG_REGS_VH
`define STG_REGS_VH
`define STG_CTRL_ADDR      8'h00
`define STG_SER_BASE       8'h10
`define STG_SER_LAST       8'h1f
`define STG_SER_DATA       8'h10
`define STG_SER_STAT       8'h12
`define STG_TMR_BASE       8'h40
`define STG_TMR_LAST       8'h4f
`define STG_TMR_CNT0       8'h40
`define STG_TMR_CNT1       8'h42
`define STG_TMR_CNT2       8'h44
`define STG_TMR_MODE       8'h46
`define STG_CTRL_RESET     8'h00
`define STG_BIT_KBD        0
`define STG_BIT_REMOTE_BAUD_CLOCK_SELECT     1
`define STG_BIT_TGATE      2
`define STG_BIT_TDATA      3
`define STG_BIT_RFSH       4
`define STG_BIT_FDCRST     5
`define STG_BIT_TMR0       6
`define STG_BIT_TMR1       7
`define STG_CPU_KHZ        8000
`define STG_SER_KHZ        2000
`define STG_T0_KHZ         1000
`define STG_DIV_STAGES     4
`define STG_ZERO8          8'h00
`endif

//--- hdl/stg_divider.v
// Four-stage binary divider producing one-cycle enable pulses.
// Assumes cpuTick marks each 8 MHz CPU clock period in the clk domain.
`timescale 1ns/1ps
`include "stg_regs.vh"
module stg_divider (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       cpuTick,
    output reg  [3:0] stageTick,
    output wire [3:0] stageLevel
);
    reg [3:0] count_reg;
    // Each stage halves the previous; a tick marks a falling edge of that stage
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= 4'h0;
            stageTick <= 4'h0;
        end else begin
            stageTick <= 4'h0;
            if (cpuTick) begin
                count_reg    <= count_reg + 4'h1;
                stageTick[0] <= (count_reg[0] == 1'b1);
                stageTick[1] <= (count_reg[1:0] == 2'b11);
                stageTick[2] <= (count_reg[2:0] == 3'b111);
                stageTick[3] <= (count_reg == 4'hf);
            end
        end
    end
    assign stageLevel = count_reg; // 4, 2, 1 MHz and 500 kHz square waves
endmodule

//--- verification/stg_glue_sva.sv
// Port checker for the serial/timer glue block.
// Assumes one clock domain and is attached to every glue instance by bind.
`timescale 1ns/1ps
module stg_glue_sva (
    input wire       clk,
    input wire       rst_b,
    input wire [7:0] perAddr,
    input wire [7:0] perWdata,
    input wire       perWr,
    input wire       perRd,
    input wire       serSel,
    input wire       tmrSel,
    input wire [1:0] tmrIndex,
    input wire       rs232RxdN,
    input wire       serRxd,
    input wire       serRxReady,
    input wire       serTxReady,
    input wire       serialIrq,
    input wire [2:0] tmrOut,
    input wire       speakerOut,
    input wire       refreshReq,
    input wire       keyboardPowerOn,
    input wire       diskControllerResetN
);
    reg  [7:0] shReg;
    reg  [1:0] quietReg;
    wire       ctrlWr = perWr && perAddr == 8'h00;
    // Shadow of the write-only port, plus cycles since it was last written
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shReg    <= 8'h00;
            quietReg <= 2'h0;
        end else begin
            if (ctrlWr) shReg <= perWdata;
            quietReg <= ctrlWr ? 2'h0 : (quietReg == 2'h3 ? quietReg : quietReg + 2'h1);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_ser_dec; perWr && perAddr[7:4] == 4'h1 && !perAddr[0] |-> serSel; endproperty
    a_ser_dec: assert property (p_ser_dec) else $error("serial select missing");
    property p_odd; (perWr || perRd) && perAddr[0] |-> !serSel && !tmrSel; endproperty
    a_odd: assert property (p_odd) else $error("odd address selected");
    property p_tmr;
        perRd && perAddr[7:4] == 4'h4 && !perAddr[0] && perAddr[2:1] != 2'h3
            |-> tmrSel && tmrIndex == perAddr[2:1];
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer decode wrong");
    property p_rxd; serRxd == !rs232RxdN; endproperty
    a_rxd: assert property (p_rxd) else $error("receive line not inverted");
    property p_irq; (serRxReady || serTxReady) [*3] |-> serialIrq; endproperty
    a_irq: assert property (p_irq) else $error("serial interrupt missing");
    property p_irq0; (!serRxReady && !serTxReady) [*3] |-> !serialIrq; endproperty
    a_irq0: assert property (p_irq0) else $error("serial interrupt stuck");
    property p_ctrl;
        ctrlWr |-> ##3 keyboardPowerOn == $past(perWdata[0], 3)
            && diskControllerResetN == $past(perWdata[5], 3);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control bits wrong");
    property p_spk; quietReg == 2'h3 && !shReg[2] |-> speakerOut == shReg[3]; endproperty
    a_spk: assert property (p_spk) else $error("direct speaker wrong");
    property p_tone;
        (quietReg == 2'h3 && shReg[3:2] == 2'h3 && $stable(tmrOut[0])) [*3]
            |-> speakerOut == tmrOut[0];
    endproperty
    a_tone: assert property (p_tone) else $error("tone not from timer");
    property p_rfsh;
        (quietReg == 2'h3 && $stable(tmrOut[2])) [*3] |-> refreshReq == (shReg[4] && tmrOut[2]);
    endproperty
    a_rfsh: assert property (p_rfsh) else $error("refresh gating wrong");
    property p_rst; $rose(rst_b) |-> !keyboardPowerOn && !diskControllerResetN; endproperty
    a_rst: assert property (p_rst) else $error("control not cleared");
    c_wr: cover property (ctrlWr);
    c_rd: cover property (perRd && serSel);
    c_tone: cover property (quietReg == 2'h3 && shReg[3:2] == 2'h3);
endmodule
bind stg_glue stg_glue_sva stg_glue_sva_i (.*);

//--- verification/stg_far.sv
// Remote serial device: modem lines and a link clock toward the connector.
// Assumes frameEn marks a frame; the clock stands still outside it.
`timescale 1ns/1ps
module stg_far (
    input  wire clk,
    input  wire rst_b,
    input  wire frameEn,
    output reg  rs232RxdN,
    output reg  rs232CtsN,
    output reg  rs232DsrN,
    output reg  rs232ClkN
);
    reg [7:0] lfsrReg;
    // Lines take a fresh LFSR bit every cycle, so a stale value seldom looks right
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lfsrReg   <= 8'h01;
            rs232RxdN <= 1'b1;
            rs232CtsN <= 1'b1;
            rs232DsrN <= 1'b1;
            rs232ClkN <= 1'b1;
        end else begin
            lfsrReg   <= {lfsrReg[6:0], lfsrReg[7] ^ lfsrReg[5] ^ lfsrReg[4] ^ lfsrReg[3]};
            rs232RxdN <= lfsrReg[0];
            rs232CtsN <= lfsrReg[1];
            rs232DsrN <= lfsrReg[2];
            rs232ClkN <= frameEn ? ~rs232ClkN : rs232ClkN;
        end
    end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the glue block with a remote serial device.
// Assumes a 250 MHz clock and one-cycle peripheral strobes.
`timescale 1ns/1ps
module tb_top;
    reg        clk, rst_b, cpuTick, perWr, perRd, serRxReady, serTxReady, serTxEmpty;
    reg        serTxd, serRts, serDtr, frameEn, rdPend;
    reg  [7:0] perAddr, perWdata, serRdata, tmrRdata, boardStrap, a, v, n0, n1, nS, nB, s0;
    reg  [7:0] s1, sS, expQ[$];
    reg  [4:0] cpuDiv;
    reg  [2:0] tmrOut;
    wire       perAck, serSel, serCmd, serWr, serRd, serClkTick, serBaudTick, serRxd, serCts;
    wire       serDsr, rs232TxdN, rs232RtsN, rs232DtrN, tmrSel, tmrWr, tmrRd, serialIrq;
    wire       speakerOut, refreshReq, keyboardPowerOn, diskControllerResetN, cpuTimer0Enable;
    wire       cpuTimer1Enable, rs232RxdN, rs232CtsN, rs232DsrN, rs232ClkN;
    wire [7:0] perRdata, serWdata, tmrWdata, boardRevision;
    wire [1:0] tmrIndex;
    wire [2:0] tmrClkTick;
    integer    i, err_total, samples_checked;
    localparam [63:0] CTRLS = 64'hff_28_00_c1_0c_0c_04_12;
    localparam [79:0] ADDRS = 80'h10_12_40_42_44_46_00_11_43_30;
    stg_glue stg_glue_i (.*);
    stg_far stg_far_i (.*);
    always #2 clk = ~clk;
    task check(input [7:0] obs, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (obs !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, obs, exp);
            end
        end
    endtask
    // One peripheral cycle; the strobe stands for exactly one edge
    task acc(input wr, input [7:0] ad, input [7:0] d);
        begin
            @(posedge clk);
            perAddr  <= ad;
            perWdata <= d;
            perWr    <= wr;
            perRd    <= !wr;
            @(posedge clk);
            perWr <= 1'b0;
            perRd <= 1'b0;
        end
    endtask
    task report_and_stop;
        begin
            $display("checks=%0d mismatches=%0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // CPU tick source, pulse counters and read-data monitor
    always @(posedge clk) begin
        cpuDiv  <= cpuDiv + 5'h1;
        cpuTick <= cpuDiv == 5'h1f;
        n0 <= n0 + {7'h0, tmrClkTick[0]};
        n1 <= n1 + {7'h0, tmrClkTick[1]};
        nS <= nS + {7'h0, serClkTick};
        nB <= nB + {7'h0, serBaudTick};
        if (rdPend && expQ.size() > 0) check(perRdata, expQ.pop_front());
        rdPend <= perRd;
    end
    initial begin
        #40000;
        err_total = err_total + 1;
        report_and_stop;
    end
    initial begin
        {clk, rst_b, cpuTick, perWr, perRd, serRxReady, serTxReady, serTxEmpty} = 8'h00;
        {serTxd, serRts, serDtr, frameEn, rdPend, perAddr, perWdata, tmrOut} = 24'h0;
        {n0, n1, nS, nB, cpuDiv, serRdata, tmrRdata} = 53'h0;
        boardStrap = 8'h5a;
        err_total = 0;
        samples_checked = 0;
        v = $urandom(32'hb227);
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check({diskControllerResetN, keyboardPowerOn, cpuTimer0Enable, cpuTimer1Enable}, 8'h0);
        check(boardRevision, 8'h5a);
        // Control port: bit map, speaker modes and refresh gating
        for (i = 0; i < 8; i = i + 1) begin
            v = (i == 7) ? $urandom : CTRLS[i*8 +: 8];
            a = $urandom;
            tmrOut <= a[2:0];
            acc(1'b1, 8'h00, v);
            repeat (4) @(posedge clk);
            #1;
            check({cpuTimer1Enable, cpuTimer0Enable, diskControllerResetN, keyboardPowerOn},
                  {v[7], v[6], v[5], v[0]});
            check(speakerOut, v[2] ? v[3] & a[0] : v[3]);
            check(refreshReq, v[4] & a[2]);
        end
        // Serial interrupt from either ready line
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk);
            {serTxReady, serRxReady} <= i;
            repeat (4) @(posedge clk);
            #1;
            check(serialIrq, i != 0);
        end
        // Modem lines are inverted both ways
        v = $urandom;
        @(posedge clk);
        {serTxd, serRts, serDtr} <= v[2:0];
        repeat (4) @(posedge clk);
        #1;
        check({rs232TxdN, rs232RtsN, rs232DtrN}, {5'h00, ~v[2:0]});
        check({serRxd, serCts, serDsr}, {5'h00, ~rs232RxdN, ~rs232CtsN, ~rs232DsrN});
        // Register reads, including unmapped, odd and no-operation places
        serRdata <= $urandom;
        tmrRdata <= $urandom;
        acc(1'b1, 8'h12, $urandom);
        for (i = 9; i >= 0; i = i - 1) begin
            a = ADDRS[i*8 +: 8];
            v = (a[0] || a == 8'h46 || (a[7:4] != 4'h1 && a[7:4] != 4'h4)) ? 8'h00
                : (a[6] ? tmrRdata : serRdata);
            expQ.push_back(v);
            acc(1'b0, a, 8'h00);
        end
        // Remote clock selected, then timer baud gated off
        frameEn <= 1'b1;
        acc(1'b1, 8'h00, 8'h02);
        s0 = nB;
        repeat (64) @(posedge clk);
        check(nB != s0, 8'h01);
        acc(1'b1, 8'h00, 8'h00);
        repeat (4) @(posedge clk);
        s0 = nB;
        repeat (64) @(posedge clk);
        check(nB - s0, 8'h00);
        // Divider rates over 64 CPU ticks
        s0 = n0;
        s1 = n1;
        sS = nS;
        repeat (2048) @(posedge clk);
        check(n0 - s0, 8'h08);
        check(n1 - s1, 8'h10);
        check(nS - sS, 8'h10);
        report_and_stop;
    end
endmodule
